//--- apr_pkg.sv
/*
 * Shared constants for the accelerometer power-mode and rate control block.
 * Assumes a 100 MHz system clock and a 4-wire SPI target port.
 */
package apr_pkg;
    // Register map
    localparam logic [5:0] ADDR_RATE_AND_POWER_SELECT = 6'h2C;
    localparam logic [5:0] ADDR_POWER_CONTROL = 6'h2D;
    // Field positions
    localparam int RATE_LSB = 0;
    localparam int RATE_W = 4;
    localparam int LOW_POWER_BIT = 4;
    localparam int MEASURE_BIT = 3;
    // Reset values
    localparam logic [7:0] RATE_AND_POWER_SELECT_RST = 8'h0A;
    localparam logic [7:0] POWER_CONTROL_RST = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // Rate codes where low-power operation lowers the internal rate
    localparam logic [3:0] LP_CODE_MIN = 4'h7;
    localparam logic [3:0] LP_CODE_MAX = 4'hC;
    localparam logic [3:0] RATE_CODE_TOP = 4'hF;
    // Timing
    localparam int CLOCK_HZ = 100_000_000;
    localparam int TOP_RATE_HZ = 3200;
    localparam int TOP_RATE_PERIOD_CYCLES = CLOCK_HZ / TOP_RATE_HZ;
    localparam int OVERSAMPLE_SHIFT = 2;
    // SPI command byte layout
    localparam int CMD_READ_BIT = 7;
    localparam int CMD_MULTI_BIT = 6;
    localparam logic [2:0] LAST_BIT_INDEX = 3'h7;
    // SPI receive phase, one-hot
    typedef enum logic [2:0] {
        APR_IDLE = 3'b001,
        APR_CMD = 3'b010,
        APR_DATA = 3'b100
    } apr_phase_t;
endpackage : apr_pkg

//--- apr_power_rate_ctrl.sv
/*
 * Power-mode and output-rate control with its SPI register target.
 * Holds the two control registers, the standby and measurement switch,
 * and a timer that paces front-end and output-sample strobes from the
 * selected rate code and the low-power bit.
 * Other register addresses read as zero and ignore writes; the sample
 * buffer itself lives outside this block and is only strobed from here.
 * Assumes an SPI master using clock polarity 1, phase 1, MSB first, with
 * chip select, clock and data arriving asynchronously to i_clock, and
 * each SCLK phase lasting at least three i_clock cycles.
 * Assumes chip select stays high while i_srst is asserted, and that the
 * consumer of the strobes runs on i_clock.
 */
`timescale 1ns/1ns

module apr_power_rate_ctrl #(
    parameter int TOP_PERIOD_CYCLES = apr_pkg::TOP_RATE_PERIOD_CYCLES,
    parameter int OS_SHIFT = apr_pkg::OVERSAMPLE_SHIFT
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_srst,
    // SPI target pins
    input wire logic i_spi_cs_n,
    input wire logic i_spi_sclk,
    input wire logic i_spi_sdi,
    output logic o_spi_sdo,
    output logic o_spi_sdo_oe,
    // Power mode
    output logic o_measuring,
    output logic o_low_power,
    output logic [3:0] o_rate_code,
    // Sample timing
    output logic o_frontend_strobe,
    output logic o_sample_write
);
    // Synchronisers
    logic [1:0] cs_sync;
    logic [1:0] sclk_sync;
    logic [1:0] sdi_sync;
    logic sclk_prev;

    // SPI and register state
    apr_pkg::apr_phase_t phase;
    apr_pkg::apr_phase_t next_phase;
    logic [2:0] bit_cnt;
    logic [2:0] next_bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] next_shift_in;
    logic [7:0] shift_out;
    logic [7:0] next_shift_out;
    logic [5:0] addr;
    logic [5:0] next_addr;
    logic is_read;
    logic next_is_read;
    logic multi;
    logic next_multi;
    logic [7:0] rate_reg;
    logic [7:0] next_rate_reg;
    logic [7:0] power_reg;
    logic [7:0] next_power_reg;
    logic sdo_oe;
    logic next_sdo_oe;

    // Rate timer state
    logic [31:0] tick_cnt;
    logic [31:0] next_tick_cnt;
    logic [7:0] os_cnt;
    logic [7:0] next_os_cnt;
    logic fe_strobe;
    logic next_fe_strobe;
    logic smp_write;
    logic next_smp_write;

    // Decoded values
    logic cs_active;
    logic sclk_rise;
    logic sclk_fall;
    logic [7:0] rd_data;
    logic [7:0] byte_in;
    logic measure;
    logic low_power;
    logic [3:0] rate_code;
    logic lp_effective;
    logic [31:0] odr_period;
    logic [31:0] int_period;
    logic [7:0] os_limit;
    logic period_end;
    logic os_wrap;

    // Decoded transfer events
    logic byte_done;
    logic cmd_done;
    logic data_done;
    logic wr_rate;
    logic wr_power;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            cs_sync <= 2'h3;
            sclk_sync <= 2'h3;
            sdi_sync <= 2'h0;
            sclk_prev <= 1'b1;
        end else begin
            cs_sync <= {cs_sync[0], i_spi_cs_n};
            sclk_sync <= {sclk_sync[0], i_spi_sclk};
            sdi_sync <= {sdi_sync[0], i_spi_sdi};
            sclk_prev <= sclk_sync[1];
        end
    end

    assign cs_active = ~cs_sync[1];
    assign sclk_rise = cs_active & sclk_sync[1] & ~sclk_prev;
    assign sclk_fall = cs_active & ~sclk_sync[1] & sclk_prev;
    assign byte_in = {shift_in[6:0], sdi_sync[1]};

    assign measure = power_reg[apr_pkg::MEASURE_BIT];
    assign low_power = rate_reg[apr_pkg::LOW_POWER_BIT];
    assign rate_code = rate_reg[apr_pkg::RATE_LSB +: apr_pkg::RATE_W];

    // Byte boundaries and register write strobes
    assign byte_done = sclk_rise && bit_cnt == apr_pkg::LAST_BIT_INDEX;
    assign cmd_done = byte_done && phase != apr_pkg::APR_DATA;
    assign data_done = byte_done && phase == apr_pkg::APR_DATA;
    assign wr_rate = data_done && !is_read
        && addr == apr_pkg::ADDR_RATE_AND_POWER_SELECT;
    assign wr_power = data_done && !is_read
        && addr == apr_pkg::ADDR_POWER_CONTROL;

    // Register read mux, same in either power mode
    always_comb begin
        unique case (addr)
            apr_pkg::ADDR_RATE_AND_POWER_SELECT: rd_data = rate_reg;
            apr_pkg::ADDR_POWER_CONTROL: rd_data = power_reg;
            default: rd_data = apr_pkg::UNMAPPED_READ;
        endcase
    end

    // SPI target: sample on rising SCLK, drive on falling SCLK
    always_comb begin
        next_phase = phase;
        next_bit_cnt = bit_cnt;
        next_shift_in = shift_in;
        next_shift_out = shift_out;
        next_addr = addr;
        next_is_read = is_read;
        next_multi = multi;
        next_sdo_oe = sdo_oe;
        if (!cs_active) begin
            next_phase = apr_pkg::APR_IDLE;
            next_bit_cnt = 3'h0;
            next_sdo_oe = 1'b0;
        end else begin
            if (phase == apr_pkg::APR_IDLE) begin
                next_phase = apr_pkg::APR_CMD;
            end
            // Shift in on every rising edge
            if (sclk_rise) begin
                next_shift_in = byte_in;
                next_bit_cnt = bit_cnt + 3'h1;
            end
            // Command byte sets direction, auto-increment and address
            if (cmd_done) begin
                next_is_read = byte_in[apr_pkg::CMD_READ_BIT];
                next_multi = byte_in[apr_pkg::CMD_MULTI_BIT];
                next_addr = byte_in[5:0];
                next_phase = apr_pkg::APR_DATA;
            end
            if (data_done && multi) begin
                next_addr = addr + 6'h01;
            end
            // Read data: load on first fall of a byte, then shift
            if (sclk_fall && phase == apr_pkg::APR_DATA && is_read) begin
                next_sdo_oe = 1'b1;
                if (bit_cnt == 3'h0) begin
                    next_shift_out = rd_data;
                end else begin
                    next_shift_out = {shift_out[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            phase <= apr_pkg::APR_IDLE;
            bit_cnt <= 3'h0;
            shift_in <= 8'h00;
            shift_out <= 8'h00;
            addr <= 6'h00;
            is_read <= 1'b0;
            multi <= 1'b0;
            sdo_oe <= 1'b0;
        end else begin
            phase <= next_phase;
            bit_cnt <= next_bit_cnt;
            shift_in <= next_shift_in;
            shift_out <= next_shift_out;
            addr <= next_addr;
            is_read <= next_is_read;
            multi <= next_multi;
            sdo_oe <= next_sdo_oe;
        end
    end

    // Register file, written at the end of a data byte
    always_comb begin
        next_rate_reg = rate_reg;
        next_power_reg = power_reg;
        if (wr_rate) begin
            next_rate_reg = byte_in;
        end
        if (wr_power) begin
            // Measure bit set or cleared here
            next_power_reg = byte_in;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            rate_reg <= apr_pkg::RATE_AND_POWER_SELECT_RST;
            power_reg <= apr_pkg::POWER_CONTROL_RST;
        end else begin
            rate_reg <= next_rate_reg;
            power_reg <= next_power_reg;
        end
    end

    // Output period doubles for each code step below the top code
    assign odr_period = 32'(TOP_PERIOD_CYCLES)
        << (apr_pkg::RATE_CODE_TOP - rate_code);
    assign lp_effective = low_power
        && rate_code >= apr_pkg::LP_CODE_MIN
        && rate_code <= apr_pkg::LP_CODE_MAX;
    // Low power with codes LP_CODE_MIN to LP_CODE_MAX drops the oversampling, lowering front-end activity
    assign int_period = lp_effective ? odr_period
        : (odr_period >> OS_SHIFT);
    assign os_limit = lp_effective ? 8'h00
        : 8'((1 << OS_SHIFT) - 1);
    // Period and oversample boundaries
    assign period_end = tick_cnt >= int_period - 32'h0000_0001;
    assign os_wrap = os_cnt >= os_limit;

    // Front end runs once per internal period, so power follows the rate
    always_comb begin
        next_tick_cnt = tick_cnt;
        next_os_cnt = os_cnt;
        next_fe_strobe = 1'b0;
        next_smp_write = 1'b0;
        if (!measure) begin
            // Standby: no strobes, buffer contents left alone
            next_tick_cnt = 32'h0000_0000;
            next_os_cnt = 8'h00;
        end else if (period_end) begin
            next_tick_cnt = 32'h0000_0000;
            next_fe_strobe = 1'b1;
            if (os_wrap) begin
                next_os_cnt = 8'h00;
                next_smp_write = 1'b1;
            end else begin
                next_os_cnt = os_cnt + 8'h01;
            end
        end else begin
            next_tick_cnt = tick_cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            tick_cnt <= 32'h0000_0000;
            os_cnt <= 8'h00;
            fe_strobe <= 1'b0;
            smp_write <= 1'b0;
        end else begin
            tick_cnt <= next_tick_cnt;
            os_cnt <= next_os_cnt;
            fe_strobe <= next_fe_strobe;
            smp_write <= next_smp_write;
        end
    end

    // Pin and status outputs
    assign o_spi_sdo = shift_out[7];
    assign o_spi_sdo_oe = sdo_oe;
    assign o_measuring = measure;
    assign o_low_power = low_power;
    assign o_rate_code = rate_code;
    assign o_frontend_strobe = fe_strobe;
    assign o_sample_write = smp_write;
endmodule : apr_power_rate_ctrl

//--- apr_chk.sv
/* Port checker for the power-mode and rate control block.
   Bound to apr_power_rate_ctrl; sees its ports only. */
`timescale 1ns/1ns
module apr_chk #(
    parameter int TOP_PERIOD_CYCLES = 8,
    parameter int OS_SHIFT = 2
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_srst,
    // SPI target pins
    input wire logic i_spi_cs_n,
    input wire logic o_spi_sdo_oe,
    // Sensing control
    input wire logic o_measuring,
    input wire logic o_low_power,
    input wire logic [3:0] o_rate_code,
    input wire logic o_frontend_strobe,
    input wire logic o_sample_write
);
    logic [31:0] gap;
    logic [31:0] next_gap;
    logic [31:0] per;
    logic seen;
    logic next_seen;
    logic lp_eff;
    logic same;
    logic [4:0] cfg_q;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);
    assign lp_eff = o_low_power && o_rate_code >= apr_pkg::LP_CODE_MIN
        && o_rate_code <= apr_pkg::LP_CODE_MAX;
    assign per = (32'(TOP_PERIOD_CYCLES)
        << (apr_pkg::RATE_CODE_TOP - o_rate_code))
        >> (lp_eff ? 32'h0 : 32'(OS_SHIFT));
    assign same = {o_low_power, o_rate_code} == cfg_q;
    // Gap since last strobe under a steady setting
    always_comb begin
        next_gap = (o_frontend_strobe || !o_measuring) ? 32'h0 : gap + 32'h1;
        next_seen = o_measuring && same && (o_frontend_strobe || seen);
    end
    always_ff @(posedge i_clock) begin
        gap <= next_gap;
        seen <= next_seen;
        cfg_q <= {o_low_power, o_rate_code};
    end
    a_reset_standby: assert property (
        $fell(i_srst) |-> !o_measuring && !o_low_power && !o_spi_sdo_oe
        && o_rate_code == apr_pkg::RATE_AND_POWER_SELECT_RST[3:0])
        else $error("bad reset state");
    a_standby_quiet: assert property (
        !o_measuring && !$past(o_measuring) |-> !o_frontend_strobe
        && !o_sample_write) else $error("pulse in standby");
    a_strobe_period: assert property (
        o_measuring && seen && same
        |-> o_frontend_strobe == (gap == per - 32'h1))
        else $error("strobe period wrong");
    a_write_on_strobe: assert property (
        o_sample_write |-> o_frontend_strobe) else $error("lone write");
    a_lp_every: assert property (
        lp_eff && seen && same && o_frontend_strobe |-> o_sample_write)
        else $error("low power write missing");
    a_strobe_single: assert property (
        o_frontend_strobe |=> !o_frontend_strobe) else $error("long pulse");
    a_sdo_released: assert property (
        i_spi_cs_n [*6] |-> !o_spi_sdo_oe) else $error("sdo driven idle");
    a_cfg_hold: assert property (
        i_spi_cs_n [*8] |-> $stable(o_measuring) && $stable(o_rate_code)
        && $stable(o_low_power)) else $error("setting moved idle");
endmodule : apr_chk
bind apr_power_rate_ctrl apr_chk #(
    .TOP_PERIOD_CYCLES(TOP_PERIOD_CYCLES),
    .OS_SHIFT(OS_SHIFT)
) u_chk (
    .i_clock(i_clock), .i_srst(i_srst), .i_spi_cs_n(i_spi_cs_n),
    .o_spi_sdo_oe(o_spi_sdo_oe), .o_measuring(o_measuring),
    .o_low_power(o_low_power), .o_rate_code(o_rate_code),
    .o_frontend_strobe(o_frontend_strobe), .o_sample_write(o_sample_write)
);

//--- apr_host.sv
/* SPI host model, mode 1/1, MSB first, six clocks per half bit.
   Assumes the caller waits for each transfer to finish. */
`timescale 1ns/1ns
module apr_host (
    // Clock
    input wire logic i_clock,
    // SPI master pins
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_sdi,
    input wire logic i_sdo
);
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b1;
        o_sdi = 1'b0;
    end
    task automatic xfer(input logic [23:0] frame, input int nb,
            output logic [15:0] rd);
        rd = 16'h0000;
        @(negedge i_clock);
        o_cs_n = 1'b0;
        repeat (6) @(negedge i_clock);
        for (int i = 0; i < 8 + 8 * nb; i++) begin
            o_sclk = 1'b0;
            o_sdi = frame[23 - i];
            repeat (6) @(negedge i_clock);
            o_sclk = 1'b1;
            rd = {rd[14:0], i_sdo};
            repeat (6) @(negedge i_clock);
        end
        o_cs_n = 1'b1;
        o_sdi = ~o_sdi;
        repeat (6) @(negedge i_clock);
    endtask : xfer
endmodule : apr_host

//--- testbench.sv
/* Self-checking bench for the power-mode and rate control block.
   Base period parameter shortened to 8 clocks. */
`timescale 1ns/1ns
module testbench;
    typedef struct packed {
        logic [7:0] rate;
        logic [31:0] per;
        logic [31:0] nw;
    } apr_row_t;
    apr_row_t rows [8] = '{
        '{8'h0F, 32'h2, 32'h1}, '{8'h0E, 32'h4, 32'h1},
        '{8'h1D, 32'h8, 32'h1}, '{8'h0C, 32'h10, 32'h1},
        '{8'h1C, 32'h40, 32'h4}, '{8'h1A, 32'h100, 32'h4},
        '{8'h17, 32'h800, 32'h4}, '{8'h16, 32'h400, 32'h1}};
    logic i_clock, i_srst, cs_n, sclk, sdi, sdo, sdo_oe;
    logic measuring, low_power, strobe, swr;
    logic [3:0] rate_code;
    logic [15:0] rd;
    logic sdo_line;
    int fails, n_compared, n, sw, tot;
    apr_power_rate_ctrl #(.TOP_PERIOD_CYCLES(8), .OS_SHIFT(2)) DUT (
        .i_clock(i_clock), .i_srst(i_srst), .i_spi_cs_n(cs_n),
        .i_spi_sclk(sclk), .i_spi_sdi(sdi), .o_spi_sdo(sdo),
        .o_spi_sdo_oe(sdo_oe), .o_measuring(measuring),
        .o_low_power(low_power), .o_rate_code(rate_code),
        .o_frontend_strobe(strobe), .o_sample_write(swr));
    // Released SDO shows the inverse, so reads need the driver on
    assign sdo_line = sdo_oe ? sdo : ~sdo;
    apr_host host (.i_clock(i_clock), .o_cs_n(cs_n), .o_sclk(sclk),
        .o_sdi(sdi), .i_sdo(sdo_line));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        if (fails == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    task automatic wait_strobe;
        n = 0;
        sw = 0;
        do begin
            @(negedge i_clock);
            n++;
            sw += int'(swr === 1'b1);
        end while (strobe !== 1'b1 && n < 5000);
    endtask : wait_strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer({a, d, 8'h00}, 1, rd);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        host.xfer({8'h80 | a, 16'h0000}, 1, rd);
        check(32'(rd[7:0]), 32'(e));
    endtask : rd_chk
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    initial begin
        repeat (80000) @(posedge i_clock);
        fails++;
        report_and_stop();
    end
    initial begin
        fails = 0;
        n_compared = 0;
        i_srst = 1'b1;
        repeat (5) @(negedge i_clock);
        i_srst = 1'b0;
        rd_chk(8'h2C, 8'h0A);
        rd_chk(8'h2D, 8'h00);
        foreach (rows[k]) begin
            wr(8'h2C, rows[k].rate);
            rd_chk(8'h2C, rows[k].rate);
            check(32'(low_power), 32'(rows[k].rate[4]));
            wr(8'h2D, 8'h08);
            check(32'(measuring), 32'h1);
            wait_strobe;
            tot = 0;
            repeat (4) begin
                wait_strobe;
                tot += sw;
            end
            check(n, rows[k].per);
            check(tot, rows[k].nw);
            wr(8'h2D, 8'h00);
            check(32'(measuring), 32'h0);
        end
        // Unmapped place, then one multi-byte setup
        wr(8'h30, 8'hFF);
        rd_chk(8'h30, 8'h00);
        host.xfer({8'h6C, 8'h1C, 8'h08}, 2, rd);
        check(32'({low_power, rate_code, measuring}), 32'h39);
        i_srst = 1'b1;
        repeat (2) @(negedge i_clock);
        i_srst = 1'b0;
        check(32'({low_power, rate_code, measuring}), 32'h14);
        report_and_stop();
    end
endmodule : testbench
